// file: inc/wtc_pkg.sv
// Package with register map, field positions, reset values and modes of the waveform timer.
`default_nettype none
package wtc_pkg;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_STATUS    = 8'h04;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h08;
	localparam logic [7:0] OFF_COUNTER   = 8'h0c;
	localparam logic [7:0] OFF_PERIOD    = 8'h10;
	localparam logic [7:0] OFF_PER_BUF   = 8'h14;
	localparam logic [7:0] OFF_CMP0      = 8'h18;
	localparam logic [7:0] OFF_CMP_BUF0  = 8'h24;
	localparam logic [7:0] OFF_DEBUG     = 8'h30;
	localparam logic [7:0] OFF_BUF_VALID = 8'h34;
	// Control register fields.
	localparam int CTRL_ENABLE   = 0;
	localparam int CTRL_SPLIT    = 1;
	localparam int CTRL_DIR_DOWN = 2;
	localparam int CTRL_EVCOUNT  = 3;
	localparam int CTRL_EVDIR    = 4;
	localparam int CTRL_EVRESTART = 5;
	localparam int CTRL_CLKSEL   = 8;
	localparam int CTRL_WGMODE   = 12;
	localparam int CTRL_CMPEN    = 16;
	// Status bits: 0 top, 1 bottom, 2..4 compare 0..2 (in split: 0 low bottom, 5 high bottom, 6..8 high compare).
	localparam int ST_TOP     = 0;
	localparam int ST_BOTTOM  = 1;
	localparam int ST_CMP     = 2;
	localparam int ST_HTOP    = 5;
	localparam int ST_HCMP    = 6;
	localparam int ST_WIDTH   = 9;
	// Waveform modes.
	typedef enum logic [1:0] {
		WTC_WG_NORMAL = 2'b00,
		WTC_WG_FRQ    = 2'b01,
		WTC_WG_SS     = 2'b10,
		WTC_WG_DS     = 2'b11
	} wtc_wg_e;
	// Reset values and bus response codes.
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;
endpackage
`default_nettype wire

// file: verilog/wtc_timer.sv
// Waveform timer/counter with three compare channels, split mode, AXI4-Lite registers and interrupt.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`default_nettype none

module wtc_timer (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// AXI4-Lite write response.
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Event inputs from the event network (asynchronous).
	input  wire logic        event_count,
	input  wire logic        event_aux,
	// Debug halt of the processor (asynchronous).
	input  wire logic        cpu_halted,
	// Waveform outputs and interrupt.
	output var  logic [5:0]  waveform_out,
	output var  logic        irq
);
	localparam int ST_W = wtc_pkg::ST_WIDTH;
	// Register state.
	logic [31:0] ctrl;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] irq_mask;
	logic [15:0] counter_value;
	logic [15:0] period;
	logic [15:0] period_buffer;
	logic [15:0] compare_value  [3];
	logic [15:0] compare_buffer [3];
	logic [3:0]  buffer_valid_flag;
	logic        debug_run_bit;
	logic [9:0]  prescale;
	logic [2:0]  ev_sync;
	logic [1:0]  aux_sync;
	logic [1:0]  halt_sync;
	logic [1:0]  aux_prev;
	// Bus handshake state.
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	// Compare of any two 8-bit or 16-bit halves, selected by split mode.
	function automatic logic [1:0] eq_split(input logic [15:0] a, input logic [15:0] b, input logic split);
		eq_split = split ? {a[15:8] == b[15:8], a[7:0] == b[7:0]} : {a == b, a == b};
	endfunction

	// Byte-lane merge of a write into a 16-bit register.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Configuration fields.
	wire        enable    = ctrl[wtc_pkg::CTRL_ENABLE];
	wire        split     = ctrl[wtc_pkg::CTRL_SPLIT];
	wire        dir_cfg   = ctrl[wtc_pkg::CTRL_DIR_DOWN];
	wire        ev_count  = ctrl[wtc_pkg::CTRL_EVCOUNT];
	wire        ev_dir    = ctrl[wtc_pkg::CTRL_EVDIR];
	wire        ev_restart = ctrl[wtc_pkg::CTRL_EVRESTART];
	wire [3:0]  clksel    = ctrl[wtc_pkg::CTRL_CLKSEL +: 4];
	wire [1:0]  wgmode    = ctrl[wtc_pkg::CTRL_WGMODE +: 2];
	wire [5:0]  cmp_en    = ctrl[wtc_pkg::CTRL_CMPEN +: 6];

	// Event and halt levels after two flops; the event edge comes from the second and third stage, the aux edge from the third and fourth.
	// Event direction and restart.
	wire        ev_edge   = ev_sync[1] & ~ev_sync[2];
	wire        aux_level = aux_sync[1];
	wire        aux_rise  = aux_prev[0] & ~aux_prev[1];
	wire        dir_down  = dir_cfg ^ (ev_dir & aux_level);
	wire        restart   = ev_restart & aux_rise;
	wire        run       = enable & (~halt_sync[1] | debug_run_bit);

	// Prescaler tap: clksel n divides by 2**n, capped at 1024 for n of 10 and above, zero meaning every cycle.
	// Prescaler or event tick.
	wire [9:0]  pre_mask  = (10'h001 << clksel) - 10'h001;
	wire        pre_tick  = (clksel == 4'h0) | ((prescale & pre_mask) == pre_mask);
	wire        tick      = run & (ev_count ? ev_edge : pre_tick);

	// Top/bottom/compare detection per half.
	// Compare with zero and period.
	wire [1:0]  at_top    = eq_split(counter_value, period, split);
	wire [1:0]  at_bottom = eq_split(counter_value, 16'h0000, split);
	wire [1:0]  cmp_eq0   = eq_split(counter_value, compare_value[0], split);
	wire [1:0]  cmp_eq1   = eq_split(counter_value, compare_value[1], split);
	wire [1:0]  cmp_eq2   = eq_split(counter_value, compare_value[2], split);
	wire [2:0]  match_lo  = {cmp_eq2[0], cmp_eq1[0], cmp_eq0[0]};
	wire [2:0]  match_hi  = {cmp_eq2[1], cmp_eq1[1], cmp_eq0[1]};
	// Update at bottom when down or dual-slope, else at top; split always counts down.
	wire        upd_at_bottom = dir_down | (wgmode == wtc_pkg::WTC_WG_DS) | split;
	wire        update    = tick & (upd_at_bottom ? at_bottom[0] : at_top[0]);

	// Next counter value.
	// Clear, reload, count.
	logic [15:0] next_counter;
	logic        ds_down;
	wire         eff_down = (wgmode == wtc_pkg::WTC_WG_DS) ? ds_down : dir_down;
	always_comb begin
		next_counter = counter_value;
		if (split) begin
			next_counter[7:0]  = at_bottom[0] ? period[7:0] : counter_value[7:0] - 8'h01;
			next_counter[15:8] = at_bottom[1] ? period[15:8] : counter_value[15:8] - 8'h01;
		end else if (wgmode == wtc_pkg::WTC_WG_FRQ && !eff_down && cmp_eq0[0]) begin
			next_counter = 16'h0000;
		end else if (eff_down) begin
			next_counter = at_bottom[0] ? period : counter_value - 16'h0001;
		end else begin
			next_counter = at_top[0] ? 16'h0000 : counter_value + 16'h0001;
		end
	end

	// AXI4-Lite decode.
	wire         wr_go   = aw_held & w_held & ~s_axi_bvalid;
	wire         rd_go   = s_axi_arvalid & s_axi_arready;
	wire [7:0]   rd_addr = s_axi_araddr;
	wire         wr_cnt  = wr_go && aw_addr == wtc_pkg::OFF_COUNTER;
	wire         wr_perb = wr_go && aw_addr == wtc_pkg::OFF_PER_BUF;
	wire [1:0]   aw_idx  = aw_addr[3:2];
	wire         wr_cmp  = wr_go && aw_addr >= wtc_pkg::OFF_CMP0 && aw_addr < wtc_pkg::OFF_CMP_BUF0;
	wire         wr_cmpb = wr_go && aw_addr >= wtc_pkg::OFF_CMP_BUF0 && aw_addr < wtc_pkg::OFF_DEBUG;
	wire [1:0]   cmp_sel  = 2'((aw_addr - wtc_pkg::OFF_CMP0) >> 2);
	wire [1:0]   cmpb_sel = 2'((aw_addr - wtc_pkg::OFF_CMP_BUF0) >> 2);
	wire         wr_known = wr_go && (aw_addr[1:0] == 2'b00) && (aw_addr <= wtc_pkg::OFF_BUF_VALID);
	logic [31:0] rd_value;
	logic        rd_known;
	always_comb begin
		rd_known = 1'b1;
		if (rd_addr == wtc_pkg::OFF_CTRL) begin
			rd_value = ctrl;
		end else if (rd_addr == wtc_pkg::OFF_STATUS) begin
			rd_value = 32'(status);
		end else if (rd_addr == wtc_pkg::OFF_IRQ_MASK) begin
			rd_value = 32'(irq_mask);
		end else if (rd_addr == wtc_pkg::OFF_COUNTER) begin
			rd_value = {16'h0000, counter_value};
		end else if (rd_addr == wtc_pkg::OFF_PERIOD) begin
			rd_value = {16'h0000, period};
		end else if (rd_addr == wtc_pkg::OFF_PER_BUF) begin
			rd_value = {16'h0000, period_buffer};
		end else if (rd_addr == wtc_pkg::OFF_CMP0 || rd_addr == 8'h1c || rd_addr == 8'h20) begin
			rd_value = {16'h0000, compare_value[2'((rd_addr - wtc_pkg::OFF_CMP0) >> 2)]};
		end else if (rd_addr == wtc_pkg::OFF_CMP_BUF0 || rd_addr == 8'h28 || rd_addr == 8'h2c) begin
			rd_value = {16'h0000, compare_buffer[2'((rd_addr - wtc_pkg::OFF_CMP_BUF0) >> 2)]};
		end else if (rd_addr == wtc_pkg::OFF_DEBUG) begin
			rd_value = {31'h0, debug_run_bit};
		end else if (rd_addr == wtc_pkg::OFF_BUF_VALID) begin
			rd_value = {28'h0, buffer_valid_flag};
		end else begin
			rd_value = 32'h0000_0000;
			rd_known = 1'b0;
		end
	end

	// Status events this tick.
	// Compare interrupts.
	wire [ST_W-1:0] events = tick ? {match_hi & {3{split}}, at_bottom[1] & split, match_lo,
	                                 at_bottom[0] & ~split, split ? at_bottom[0] : at_top[0]} : '0;
	wire [ST_W-1:0] st_clear = (wr_go && aw_addr == wtc_pkg::OFF_STATUS && w_strb != 4'h0) ?
	                           w_data[ST_W-1:0] : '0;

	// Write address and data capture, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	// Bus handshake outputs.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= wtc_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= wtc_pkg::RESP_OKAY;
			s_axi_rdata   <= 32'h0;
		end else begin
			s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready  <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? wtc_pkg::RESP_OKAY : wtc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_value;
				s_axi_rresp  <= rd_known ? wtc_pkg::RESP_OKAY : wtc_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Synchronisers and prescaler.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_sync   <= 3'b000;
			aux_sync  <= 2'b00;
			aux_prev  <= 2'b00;
			halt_sync <= 2'b00;
			prescale  <= 10'h000;
		end else begin
			ev_sync   <= {ev_sync[1:0], event_count};
			aux_sync  <= {aux_sync[0], event_aux};
			aux_prev  <= {aux_prev[0], aux_sync[1]};
			halt_sync <= {halt_sync[0], cpu_halted};
			prescale  <= run ? prescale + 10'h001 : prescale;
		end
	end

	// Control, mask, debug and status registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl          <= wtc_pkg::CTRL_RESET;
			irq_mask      <= '0;
			debug_run_bit <= 1'b0;
			status        <= '0;
			irq           <= 1'b0;
		end else begin
			if (wr_go && aw_addr == wtc_pkg::OFF_CTRL) begin
				ctrl <= w_data;
			end
			if (wr_go && aw_addr == wtc_pkg::OFF_IRQ_MASK) begin
				irq_mask <= w_data[ST_W-1:0];
			end
			if (wr_go && aw_addr == wtc_pkg::OFF_DEBUG) begin
				debug_run_bit <= w_data[0];
			end
			// Event set wins over a write-one clear.
			status <= (status & ~st_clear) | events;
			irq    <= |(((status & ~st_clear) | events) & irq_mask);
		end
	end

	// Counter, period, compare and buffer registers.
	// Sixteen-bit storage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter_value     <= 16'h0000;
			period            <= wtc_pkg::PERIOD_RESET;
			period_buffer     <= 16'h0000;
			compare_value     <= '{default: 16'h0000};
			compare_buffer    <= '{default: 16'h0000};
			buffer_valid_flag <= 4'h0;
			ds_down           <= 1'b0;
		end else begin
			// Counter write has priority over count, clear and reload.
			if (wr_cnt) begin
				counter_value <= merge16(counter_value, w_data, w_strb);
			end else if (restart) begin
				counter_value <= dir_down ? period : 16'h0000;
			end else if (tick) begin
				counter_value <= next_counter;
			end
			if (tick && wgmode == wtc_pkg::WTC_WG_DS) begin
				ds_down <= at_top[0] ? 1'b1 : (at_bottom[0] ? 1'b0 : ds_down);
			end
			if (wr_go && aw_addr == wtc_pkg::OFF_PERIOD) begin
				period <= merge16(period, w_data, w_strb);
			end else if (update && buffer_valid_flag[3]) begin
				period <= period_buffer;
			end
			if (wr_perb) begin
				period_buffer <= merge16(period_buffer, w_data, w_strb);
			end
			for (int i = 0; i < 3; i++) begin
				if (wr_cmp && cmp_sel == 2'(i)) begin
					compare_value[i] <= merge16(compare_value[i], w_data, w_strb);
				end else if (update && buffer_valid_flag[i]) begin
					compare_value[i] <= compare_buffer[i];
				end
				if (wr_cmpb && cmpb_sel == 2'(i)) begin
					compare_buffer[i] <= merge16(compare_buffer[i], w_data, w_strb);
				end
			end
			// Set on write wins over update clear.
			buffer_valid_flag <= (buffer_valid_flag & ~{4{update}}) |
			                     {wr_perb, wr_cmpb && cmpb_sel == 2'd2, wr_cmpb && cmpb_sel == 2'd1,
			                      wr_cmpb && cmpb_sel == 2'd0};
		end
	end

	// Waveform outputs.
	// Waveforms from comparisons.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			waveform_out <= 6'h00;
		end else if (split) begin
			for (int i = 0; i < 3; i++) begin
				waveform_out[i]   <= cmp_en[i] & (counter_value[7:0] < compare_value[i][7:0]);
				waveform_out[i+3] <= cmp_en[i+3] & (counter_value[15:8] < compare_value[i][15:8]);
			end
		end else begin
			waveform_out[5:3] <= 3'b000;
			for (int i = 0; i < 3; i++) begin
				if (!cmp_en[i] || ev_count || wgmode == wtc_pkg::WTC_WG_NORMAL) begin
					waveform_out[i] <= 1'b0;
				end else if (wgmode == wtc_pkg::WTC_WG_FRQ) begin
					waveform_out[i] <= waveform_out[i] ^ (tick & match_lo[i]);
				end else begin
					waveform_out[i] <= counter_value < compare_value[i];
				end
			end
		end
	end
	wire unused_ok = ^{aw_idx, compare_value[0][0]};
endmodule
`default_nettype wire

// file: test/wtc_timer_assertions.sv
// Checker with concurrent properties on the waveform timer ports.
`default_nettype none
module wtc_timer_assertions (
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register bus.
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Waveform and interrupt outputs.
	input wire logic [5:0]  waveform_out,
	input wire logic        irq
);
	logic [7:0] aw_q;
	logic       sw_q;
	logic       busy_q;
	logic       split_q;
	// Shadow of the split bit, updated only once a control write has completed.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q    <= 8'h00;
			sw_q    <= 1'b0;
			busy_q  <= 1'b0;
			split_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) sw_q <= s_axi_wdata[1];
			if (s_axi_awvalid || s_axi_wvalid) busy_q <= 1'b1;
			else if (s_axi_bvalid && s_axi_bready) busy_q <= 1'b0;
			if (s_axi_bvalid && s_axi_bready && aw_q == 8'h00) split_q <= sw_q;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_offer;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	endsequence
	reset_quiet_a: assert property ($rose(aresetn) |-> waveform_out == 6'h00 && !irq)
		else $error("outputs not quiet after reset");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	read_answer_a: assert property (ar_taken |=> s_axi_rvalid)
		else $error("read answer late");
	write_answer_a: assert property (wr_offer |-> ##[1:6] s_axi_bvalid)
		else $error("write answer late");
	no_overlap_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write taken while response pending");
	error_zero_a: assert property (s_axi_rvalid && s_axi_rresp == wtc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	unmapped_read_a: assert property (ar_taken ##0 s_axi_araddr > 8'h34 |=> s_axi_rresp == wtc_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	upper_idle_a: assert property (!busy_q && !split_q && !$past(split_q) && !$past(split_q, 2)
		|-> waveform_out[5:3] == 3'b000)
		else $error("upper outputs driven outside split");
endmodule
`default_nettype wire

// file: test/wtc_event_src.sv
// Model of the event network that feeds the waveform timer.
`default_nettype none
module wtc_event_src (
	// Clock.
	input  wire logic aclk,
	// Event lines toward the timer.
	output var  logic event_count,
	output var  logic event_aux
);
	timeunit 1ns;
	timeprecision 1ps;
	// Both lines start idle.
	initial begin
		event_count = 1'b0;
		event_aux   = 1'b0;
	end
	// events as configured
	// Each event is held long enough to pass the two-flop synchroniser.
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge aclk);
			event_count <= 1'b1;
			repeat (3) @(posedge aclk);
			event_count <= 1'b0;
			repeat (3) @(posedge aclk);
		end
	endtask
	task automatic set_aux(input logic v);
		@(posedge aclk);
		event_aux <= v;
	endtask
endmodule
`default_nettype wire

// file: test/wtc_timer_test.sv
// Self-checking bench for the waveform timer.
`default_nettype none
module wtc_timer_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0, halted = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, ev_cnt, ev_aux, irq;
	logic [1:0]  bresp, rresp, b_r, r_r;
	logic [31:0] rdata, r_d;
	logic [5:0]  wave, seen;
	logic [31:0] seed = 32'h76f7436d;
	int          fails = 0;
	int          n_tests = 0;
	// Free-running 200 MHz clock.
	always #2.5 aclk = ~aclk;
	wtc_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_count(ev_cnt),
		.event_aux(ev_aux), .cpu_halted(halted), .waveform_out(wave), .irq(irq));
	wtc_event_src ev (.aclk(aclk), .event_count(ev_cnt), .event_aux(ev_aux));
	// Random source.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Expected counter after n events from a start value.
	function automatic logic [31:0] after_ev(input logic [15:0] s, input int n, input logic down);
		return {16'h0, down ? s - 16'(n) : s + 16'(n)};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic nap(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// Collects every waveform bit seen high over n cycles.
	task automatic watch(input int n);
		seen = 6'h0;
		repeat (n) begin
			@(posedge aclk);
			seen = seen | wave;
		end
	endtask
	// Bus write: address and data offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		b_r = bresp;
	endtask
	// Bus read: the word and response are taken at the edge where rvalid is seen.
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		r_r = rresp;
		r_d = rdata;
	endtask
	// Bus read, then compare against the expected word.
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(r_d, e);
	endtask
	task automatic close_out();
		$display("Counts: %0d compares, %0d mismatches", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Watchdog cuts a hang short.
	initial begin
		nap(30000);
		fails++;
		close_out();
	end
	// Main sequence.
	initial begin
		logic [15:0] cb [3];
		int          n;
		nap(8);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(wtc_pkg::OFF_CTRL, wtc_pkg::CTRL_RESET);
		rc(wtc_pkg::OFF_PERIOD, {16'h0, wtc_pkg::PERIOD_RESET});
		rc(8'h38, 32'h0);
		chk({30'h0, r_r}, {30'h0, wtc_pkg::RESP_SLVERR});
		wr(8'h3c, 32'h1);
		chk({30'h0, b_r}, {30'h0, wtc_pkg::RESP_SLVERR});
		$display("Test done: reset and map");
		for (int k = 0; k < 3; k++) begin
			seed = xs(seed);
			cb[k] = seed[31:16];
			wr(wtc_pkg::OFF_CMP0 + 8'(4 * k), seed);
			rc(wtc_pkg::OFF_CMP0 + 8'(4 * k), {16'h0, seed[15:0]});
			wr(wtc_pkg::OFF_CMP_BUF0 + 8'(4 * k), {16'h0, cb[k]});
		end
		wr(wtc_pkg::OFF_PER_BUF, 32'h100);
		wr(wtc_pkg::OFF_PERIOD, 32'h40);
		rc(wtc_pkg::OFF_BUF_VALID, 32'hf);
		wr(wtc_pkg::OFF_CTRL, 32'h1);
		rc(wtc_pkg::OFF_PERIOD, 32'h40);
		nap(120);
		rc(wtc_pkg::OFF_PERIOD, 32'h100);
		rc(wtc_pkg::OFF_BUF_VALID, 32'h0);
		for (int k = 0; k < 3; k++) rc(wtc_pkg::OFF_CMP0 + 8'(4 * k), {16'h0, cb[k]});
		$display("Test done: buffering");
		for (int k = 0; k < 3; k++) wr(wtc_pkg::OFF_CMP0 + 8'(4 * k), 32'hffff);
		wr(wtc_pkg::OFF_COUNTER, 32'hf0);
		wr(wtc_pkg::OFF_STATUS, 32'h1ff);
		rc(wtc_pkg::OFF_STATUS, 32'h0);
		nap(12);
		rc(wtc_pkg::OFF_STATUS, 32'h3);
		wr(wtc_pkg::OFF_CTRL, 32'h5);
		wr(wtc_pkg::OFF_COUNTER, 32'h8);
		wr(wtc_pkg::OFF_STATUS, 32'h1ff);
		nap(10);
		rc(wtc_pkg::OFF_STATUS, 32'h3);
		rd(wtc_pkg::OFF_COUNTER);
		chk({31'h0, r_d[15:0] >= 16'he0 && r_d[15:0] <= 16'h100}, 32'h1);
		$display("Test done: count ends");
		wr(wtc_pkg::OFF_CMP0, 32'h80);
		wr(wtc_pkg::OFF_STATUS, 32'h1ff);
		wr(wtc_pkg::OFF_IRQ_MASK, 32'h0);
		nap(300);
		chk({31'h0, irq}, 32'h0);
		wr(wtc_pkg::OFF_CTRL, 32'h0);
		rc(wtc_pkg::OFF_STATUS, 32'h7);
		wr(wtc_pkg::OFF_IRQ_MASK, 32'h4);
		nap(3);
		chk({31'h0, irq}, 32'h1);
		wr(wtc_pkg::OFF_STATUS, 32'h4);
		nap(3);
		chk({31'h0, irq}, 32'h0);
		$display("Test done: interrupt");
		wr(wtc_pkg::OFF_CTRL, 32'h1);
		halted <= 1'b1;
		nap(6);
		rd(wtc_pkg::OFF_COUNTER);
		nap(20);
		rc(wtc_pkg::OFF_COUNTER, r_d);
		wr(wtc_pkg::OFF_DEBUG, 32'h1);
		wr(wtc_pkg::OFF_COUNTER, 32'h0);
		nap(20);
		rd(wtc_pkg::OFF_COUNTER);
		chk({31'h0, r_d > 32'h14}, 32'h1);
		halted <= 1'b0;
		$display("Test done: debug halt");
		seed = xs(seed);
		n = 1 + int'(seed[2:0]);
		wr(wtc_pkg::OFF_PERIOD, 32'hffff);
		wr(wtc_pkg::OFF_CTRL, 32'h9);
		wr(wtc_pkg::OFF_COUNTER, 32'h0);
		ev.pulses(n);
		nap(8);
		rc(wtc_pkg::OFF_COUNTER, after_ev(16'h0, n, 1'b0));
		wr(wtc_pkg::OFF_CTRL, 32'h19);
		ev.set_aux(1'b1);
		wr(wtc_pkg::OFF_COUNTER, 32'h10);
		ev.pulses(n);
		nap(8);
		rc(wtc_pkg::OFF_COUNTER, after_ev(16'h10, n, 1'b1));
		ev.set_aux(1'b0);
		wr(wtc_pkg::OFF_CTRL, 32'h29);
		ev.set_aux(1'b1);
		nap(6);
		rc(wtc_pkg::OFF_COUNTER, 32'h0);
		ev.set_aux(1'b0);
		$display("Test done: events");
		wr(wtc_pkg::OFF_PERIOD, 32'h20);
		for (int k = 0; k < 3; k++) wr(wtc_pkg::OFF_CMP0 + 8'(4 * k), 32'h8);
		wr(wtc_pkg::OFF_CTRL, 32'h3f2001);
		watch(100);
		chk({29'h0, seen[5:3]}, 32'h0);
		chk({31'h0, |seen[2:0]}, 32'h1);
		wr(wtc_pkg::OFF_CTRL, 32'h3f1001);
		watch(100);
		chk({31'h0, |seen[2:0]}, 32'h1);
		rd(wtc_pkg::OFF_COUNTER);
		chk({31'h0, r_d <= 32'h8}, 32'h1);
		wr(wtc_pkg::OFF_PERIOD, 32'h2020);
		for (int k = 0; k < 3; k++) wr(wtc_pkg::OFF_CMP0 + 8'(4 * k), 32'h808);
		wr(wtc_pkg::OFF_CTRL, 32'h3f2003);
		watch(200);
		chk({31'h0, |seen[5:3]}, 32'h1);
		$display("Test done: waveforms");
		close_out();
	end
endmodule
bind wtc_timer wtc_timer_assertions chk_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.waveform_out(waveform_out), .irq(irq));
`default_nettype wire
